// [ilp_predecoder.sv]
//------------------------------------------------------------------------------
// Purpose: predecode lines during cache fill, answer decoder lookups
// Assumes: fill and lookup driven by core logic on the core clock
// Notes: lookup answer appears two edges after the request
//------------------------------------------------------------------------------
// Behaviour
// - Predecode is produced while a line fills and stored in a cache the decoders read.
// - Only packed multimedia instructions, minus state clears and the line hint, are predecoded.
// - A predecodable instruction is at most seven bytes long.
// - Length comes from the first three bytes only, anything needing more is rejected.
// - Length uses the opcode byte plus the operand addressing byte where one exists.
// - An escape prefix byte is examined together with opcode and addressing byte.
// - An addressing byte selecting a scaled index byte with no displacement is rejected.
// - Register indirect through the source index register with no displacement is rejected.
// - No scan past the line end, so escape starts in the last two bytes are rejected.
// - Every packed multimedia instruction is sized from escape, opcode and addressing byte.
// - A packed float form with a 32-bit displacement and suffix is eight bytes and rejected.
// - Failed packed integer forms take the vector path, packed float forms the long path.
// - Cost is half a cycle paired short, one cycle long, two cycles vector.
`timescale 1ns/10ps
module ilp_predecoder #(
  parameter int LINES = 64,
  parameter int IDX_W = 6
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // cache fill side
  input wire logic fill_valid,
  input wire logic [IDX_W-1:0] fill_line,
  input wire logic [8*ilp_pkg::LINE_BYTES-1:0] fill_data,
  // decoder lookup
  input wire logic rd_valid,
  input wire logic [IDX_W-1:0] rd_line,
  input wire logic [ilp_pkg::OFF_W-1:0] rd_offset,
  // lookup answer
  output logic res_valid,
  output logic res_pred,
  output logic [2:0] res_len,
  output logic res_pf,
  output logic res_pair,
  output ilp_pkg::ilp_path_e res_path,
  output logic [2:0] res_cost
);

  localparam int NB = ilp_pkg::LINE_BYTES;
  localparam int IW = ilp_pkg::INFO_W;

  typedef struct packed {
    logic rd;
    logic [ilp_pkg::OFF_W-1:0] off;
    logic valid;
    logic pred;
    logic [2:0] len;
    logic pf;
    logic pair;
    ilp_pkg::ilp_path_e path;
    logic [2:0] cost;
  } ilp_state_s;

  ilp_state_s st_q;
  ilp_state_s st_d;
  logic [8*NB+15:0] line_x;
  logic [IW*NB-1:0] info_line;
  logic [IW*NB-1:0] rd_data;

  assign line_x = {16'h0000, fill_data};

  //----------------------------------------------------------------------------
  // per byte predecode
  //----------------------------------------------------------------------------
  for (genvar i = 0; i < NB; i++)
  begin : g_byte
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [1:0] md;
    logic [2:0] rm;
    logic is_pi;
    logic is_pf;
    logic has_imm;
    logic has_sib;
    logic [3:0] disp;
    logic [3:0] len4;
    logic bad;

    assign b0 = line_x[8*i +: 8];
    assign b1 = line_x[8*i+8 +: 8];
    assign b2 = line_x[8*i+16 +: 8];
    assign md = b2[7:6];
    assign rm = b2[2:0];
    // escape byte checked with the opcode
    // escape plus opcode
    assign is_pi = (b0 == ilp_pkg::ESC_BYTE) && (((b1 >= ilp_pkg::OP_PI_LO)
      && (b1 <= ilp_pkg::OP_PI_HI) && (b1 != ilp_pkg::OP_STATE_CLEAR))
      || (b1 >= ilp_pkg::OP_PI_UPPER));
    assign is_pf = (b0 == ilp_pkg::ESC_BYTE) && (b1 == ilp_pkg::OP_PF_GROUP);
    assign has_imm = (b1 >= ilp_pkg::OP_IMM_LO) && (b1 <= ilp_pkg::OP_IMM_HI);
    assign has_sib = (md != ilp_pkg::MOD_REG) && (rm == ilp_pkg::RM_SIB);
    // displacement size from the addressing byte
    // opcode plus addressing byte
    always_comb
    begin
      disp = 4'h0;
      unique case (md)
        ilp_pkg::MOD_NODISP: disp = (rm == ilp_pkg::RM_DISP32) ? ilp_pkg::DISP32_LEN : 4'h0;
        ilp_pkg::MOD_DISP8: disp = ilp_pkg::DISP8_LEN;
        ilp_pkg::MOD_DISP32: disp = ilp_pkg::DISP32_LEN;
        ilp_pkg::MOD_REG: disp = 4'h0;
      endcase
    end
    assign len4 = ilp_pkg::BASE_LEN + {3'h0, has_sib} + disp + {3'h0, has_imm & is_pi}
      + {3'h0, is_pf};
    // no scan past the line end
    assign bad = ((md == ilp_pkg::MOD_NODISP) && (rm == ilp_pkg::RM_SIB))
      || ((md == ilp_pkg::MOD_NODISP) && (rm == ilp_pkg::RM_SRC_INDEX))
      || (len4 > ilp_pkg::MAX_LEN) || (i > ilp_pkg::LAST_START);
    assign info_line[IW*i +: IW] = {is_pf, (is_pi | is_pf) & ~bad, len4[2:0]};
  end

  //----------------------------------------------------------------------------
  // predecode cache
  //----------------------------------------------------------------------------
  // stored during the fill
  ilp_pdc_mem #(
    .WIDTH(IW*NB),
    .DEPTH(LINES),
    .AW(IDX_W)
  ) u_mem (
    .clock(clock),
    .wr_en(fill_valid),
    .wr_addr(fill_line),
    .wr_data(info_line),
    .rd_en(rd_valid),
    .rd_addr(rd_line),
    .rd_data(rd_data)
  );

  //----------------------------------------------------------------------------
  // lookup result and decode path
  //----------------------------------------------------------------------------
  logic [IW-1:0] cur;
  logic [IW-1:0] nxt;
  logic [5:0] nxt_off;

  assign cur = rd_data[IW*st_q.off +: IW];
  assign nxt_off = {1'b0, st_q.off} + {3'h0, cur[2:0]};
  assign nxt = rd_data[IW*nxt_off[4:0] +: IW];

  // next state of lookup pipeline
  always_comb
  begin
    st_d = st_q;
    st_d.rd = rd_valid;
    st_d.off = rd_valid ? rd_offset : st_q.off;
    st_d.valid = st_q.rd;
    if (st_q.rd)
    begin
      st_d.pred = cur[ilp_pkg::INFO_VALID_BIT];
      st_d.len = cur[2:0];
      st_d.pf = cur[ilp_pkg::INFO_PF_BIT];
      st_d.pair = cur[ilp_pkg::INFO_VALID_BIT] && (nxt_off < 6'(NB))
        && nxt[ilp_pkg::INFO_VALID_BIT];
      if (cur[ilp_pkg::INFO_VALID_BIT])
      begin
        st_d.path = ilp_pkg::ILP_PATH_SHORT;
        st_d.cost = st_d.pair ? ilp_pkg::COST_PAIRED_SHORT : ilp_pkg::COST_SINGLE_SHORT;
      end
      else if (cur[ilp_pkg::INFO_PF_BIT])
      begin
        st_d.path = ilp_pkg::ILP_PATH_LONG;
        st_d.cost = ilp_pkg::COST_LONG;
      end
      else
      begin
        st_d.path = ilp_pkg::ILP_PATH_VECTOR;
        st_d.cost = ilp_pkg::COST_VECTOR;
      end
    end
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign res_valid = st_q.valid;
  assign res_pred = st_q.pred;
  assign res_len = st_q.len;
  assign res_pf = st_q.pf;
  assign res_pair = st_q.pair;
  assign res_path = st_q.path;
  assign res_cost = st_q.cost;

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  property p_answer_latency;
    @(posedge clock) disable iff (sys_rst) rd_valid |-> ##2 res_valid;
  endproperty
  a_answer_latency: assert property (p_answer_latency) else $error("answer not two cycles late");

  property p_len_limit;
    @(posedge clock) disable iff (sys_rst) (res_valid && res_pred) |-> (!res_pf
      || (res_len >= 3'h4)) && (res_len >= 3'h3);
  endproperty
  a_len_limit: assert property (p_len_limit) else $error("predecoded length out of range");

  property p_line_end;
    @(posedge clock) disable iff (sys_rst) fill_valid |-> !info_line[IW*30+3] && !info_line[IW*31+3];
  endproperty
  a_line_end: assert property (p_line_end) else $error("start in last two bytes marked valid");

  property p_sib_reject;
    @(posedge clock) disable iff (sys_rst) (fill_valid && fill_data[23:22] == 2'h0
      && fill_data[18:16] == 3'h4) |-> !info_line[3];
  endproperty
  a_sib_reject: assert property (p_sib_reject) else $error("index byte form marked valid");

  property p_esi_reject;
    @(posedge clock) disable iff (sys_rst) (fill_valid && fill_data[23:22] == 2'h0
      && fill_data[18:16] == 3'h6) |-> !info_line[3];
  endproperty
  a_esi_reject: assert property (p_esi_reject) else $error("source index form marked valid");

  property p_clear_reject;
    @(posedge clock) disable iff (sys_rst) (fill_valid && fill_data[15:8] == 8'h77) |-> !info_line[3];
  endproperty
  a_clear_reject: assert property (p_clear_reject) else $error("state clear marked valid");

  property p_fallback;
    @(posedge clock) disable iff (sys_rst) (res_valid && !res_pred) |->
      (res_path == (res_pf ? ilp_pkg::ILP_PATH_LONG : ilp_pkg::ILP_PATH_VECTOR));
  endproperty
  a_fallback: assert property (p_fallback) else $error("wrong fallback path");

  property p_cost;
    @(posedge clock) disable iff (sys_rst) res_valid |-> (res_cost == ((res_path
      == ilp_pkg::ILP_PATH_VECTOR) ? 3'h4 : (res_pair ? 3'h1 : 3'h2)));
  endproperty
  a_cost: assert property (p_cost) else $error("decode cost mismatch");

  property p_valid_short;
    @(posedge clock) disable iff (sys_rst) res_valid |-> (res_pred == (res_path
      == ilp_pkg::ILP_PATH_SHORT)) && (!res_pair || res_pred);
  endproperty
  a_valid_short: assert property (p_valid_short) else $error("valid flag and path disagree");

endmodule

// [ilp_pkg.sv]
//------------------------------------------------------------------------------
// Purpose: shared constants and types for the instruction length predecoder
// Assumes: 32-byte cache lines, one line presented per fill beat
// Notes: decode cost is kept in half cycles so that 0.5 cycle is a whole count
//------------------------------------------------------------------------------
package ilp_pkg;

  //----------------------------------------------------------------------------
  // line and entry layout
  //----------------------------------------------------------------------------
  localparam int LINE_BYTES = 32;
  localparam int OFF_W = 5;
  localparam int INFO_W = 5;
  localparam int INFO_LEN_LSB = 0;
  localparam int INFO_VALID_BIT = 3;
  localparam int INFO_PF_BIT = 4;
  localparam int LAST_START = 29;
  localparam logic [3:0] MAX_LEN = 4'h7;
  localparam logic [3:0] BASE_LEN = 4'h3;
  localparam logic [3:0] DISP8_LEN = 4'h1;
  localparam logic [3:0] DISP32_LEN = 4'h4;
  localparam int RD_LATENCY = 2;

  //----------------------------------------------------------------------------
  // opcode bytes of interest
  //----------------------------------------------------------------------------
  localparam logic [7:0] ESC_BYTE = 8'h0f;
  localparam logic [7:0] OP_PF_GROUP = 8'h0f;
  localparam logic [7:0] OP_STATE_CLEAR = 8'h77;
  localparam logic [7:0] OP_FAST_STATE_CLEAR = 8'h0e;
  localparam logic [7:0] OP_LINE_HINT = 8'h0d;
  localparam logic [7:0] OP_PI_LO = 8'h60;
  localparam logic [7:0] OP_PI_HI = 8'h7f;
  localparam logic [7:0] OP_PI_UPPER = 8'hd0;
  localparam logic [7:0] OP_IMM_LO = 8'h70;
  localparam logic [7:0] OP_IMM_HI = 8'h73;
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP32 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_SIB = 3'h4;
  localparam logic [2:0] RM_DISP32 = 3'h5;
  localparam logic [2:0] RM_SRC_INDEX = 3'h6;

  //----------------------------------------------------------------------------
  // decode paths and cost in half cycles
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ILP_PATH_NONE = 2'b00,
    ILP_PATH_SHORT = 2'b01,
    ILP_PATH_LONG = 2'b10,
    ILP_PATH_VECTOR = 2'b11
  } ilp_path_e;

  localparam logic [2:0] COST_PAIRED_SHORT = 3'h1;
  localparam logic [2:0] COST_SINGLE_SHORT = 3'h2;
  localparam logic [2:0] COST_LONG = 3'h2;
  localparam logic [2:0] COST_VECTOR = 3'h4;

endpackage

// [ilp_pdc_mem.sv]
//------------------------------------------------------------------------------
// Purpose: predecode cache storage, one entry per instruction cache line
// Assumes: one write and one read port, read data registered
// Notes: contents are not reset; a line is valid only after its fill
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module ilp_pdc_mem #(
  parameter int WIDTH = 160,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // clock
  input wire logic clock,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write then registered read
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// [ilp_fill_model.sv]
//------------------------------------------------------------------------------
// Purpose: cache fill side model that hands whole lines to the predecoder
// Assumes: one line per beat, driven just after a rising edge
// Notes: while idle the line bus shows the inverse of the last line
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module ilp_fill_model #(
  parameter int IDX_W = 6
) (
  // clock
  input wire logic clock,
  // fill beat
  output logic fill_valid,
  output logic [IDX_W-1:0] fill_line,
  output logic [8*ilp_pkg::LINE_BYTES-1:0] fill_data
);
  //----------------------------------------------------------------------------
  // idle state at time zero
  //----------------------------------------------------------------------------
  initial
  begin
    fill_valid = 1'b0;
    fill_line = '0;
    fill_data = '0;
  end

  //----------------------------------------------------------------------------
  // one fill beat
  //----------------------------------------------------------------------------
  // whole line beat
  task automatic put_line(input logic [IDX_W-1:0] idx,
                          input logic [8*ilp_pkg::LINE_BYTES-1:0] d);
    @(posedge clock);
    fill_valid <= 1'b1;
    fill_line <= idx;
    fill_data <= d;
    @(posedge clock);
    fill_valid <= 1'b0; // beat taken at this edge
    fill_line <= ~idx;
    fill_data <= ~d;
  endtask
endmodule

// [instruction_length_predecoder_test.sv]
//------------------------------------------------------------------------------
// Purpose: self-checking bench for the instruction length predecoder
// Assumes: lookup answer two edges after the request
// Notes: ordinary cases run from a table, edge cases by hand
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module instruction_length_predecoder_test;
  localparam int IDX_W = 6;
  localparam int NROWS = 16;
  localparam ilp_pkg::ilp_path_e p_sh = ilp_pkg::ILP_PATH_SHORT;
  localparam ilp_pkg::ilp_path_e p_lg = ilp_pkg::ILP_PATH_LONG;
  localparam ilp_pkg::ilp_path_e p_vc = ilp_pkg::ILP_PATH_VECTOR;
  typedef logic [8*ilp_pkg::LINE_BYTES-1:0] ilp_line_t;
  typedef struct {
    logic [23:0] b;
    logic pred;
    logic [2:0] len;
    logic pf;
    ilp_pkg::ilp_path_e path;
  } ilp_row_s;

  logic clock;
  logic sys_rst;
  logic fill_valid;
  logic [IDX_W-1:0] fill_line;
  ilp_line_t fill_data;
  logic rd_valid;
  logic [IDX_W-1:0] rd_line;
  logic [ilp_pkg::OFF_W-1:0] rd_offset;
  logic res_valid;
  logic res_pred;
  logic [2:0] res_len;
  logic res_pf;
  logic res_pair;
  ilp_pkg::ilp_path_e res_path;
  logic [2:0] res_cost;
  int num_errors;
  int checks;
  ilp_row_s rows [NROWS];
  ilp_line_t ln;

  //----------------------------------------------------------------------------
  // design and fill model
  //----------------------------------------------------------------------------
  ilp_predecoder #(.LINES(64), .IDX_W(IDX_W)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .fill_valid(fill_valid), .fill_line(fill_line),
    .fill_data(fill_data), .rd_valid(rd_valid), .rd_line(rd_line), .rd_offset(rd_offset),
    .res_valid(res_valid), .res_pred(res_pred), .res_len(res_len), .res_pf(res_pf),
    .res_pair(res_pair), .res_path(res_path), .res_cost(res_cost));
  ilp_fill_model #(.IDX_W(IDX_W)) u_fill (
    .clock(clock), .fill_valid(fill_valid), .fill_line(fill_line), .fill_data(fill_data));

  // 25 MHz clock
  initial clock = 1'b0;
  always #20 clock = ~clock;

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  function automatic logic [2:0] exp_cost(input ilp_pkg::ilp_path_e p, input logic pair);
    if (p == p_vc) return ilp_pkg::COST_VECTOR;
    if (p == p_lg) return ilp_pkg::COST_LONG;
    return pair ? ilp_pkg::COST_PAIRED_SHORT : ilp_pkg::COST_SINGLE_SHORT;
  endfunction

  task automatic chk(input logic ok, input string what);
    checks++;
    if (!ok)
    begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  // one lookup, answer checked one edge after it is taken
  task automatic lookup(input logic [IDX_W-1:0] l, input logic [4:0] off, input logic pred,
                        input logic [2:0] len, input logic pf, input logic pair,
                        input ilp_pkg::ilp_path_e path);
    @(posedge clock);
    rd_valid <= 1'b1;
    rd_line <= l;
    rd_offset <= off;
    @(posedge clock);
    rd_valid <= 1'b0;
    #1;
    chk(res_valid === 1'b0, "answer too early");
    @(posedge clock);
    #1;
    chk(res_valid === 1'b1, "no answer");
    chk(res_pred === pred, "valid flag");
    if (pred === 1'b1) chk(res_len === len, "length");
    chk(res_pf === pf, "float class");
    chk(res_pair === pair, "pairing");
    chk(res_path === path, "decode path");
    chk(res_cost === exp_cost(path, pair), "decode cost");
    @(posedge clock);
    #1;
    chk(res_valid === 1'b0, "answer pulse too long");
  endtask

  task automatic chk_idle();
    chk(res_valid === 1'b0 && res_pred === 1'b0 && res_len === 3'h0 && res_pf === 1'b0
        && res_pair === 1'b0 && res_path === ilp_pkg::ILP_PATH_NONE && res_cost === 3'h0,
        "outputs not cleared by reset");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    rd_valid = 1'b0;
    rd_line = '0;
    rd_offset = '0;
    rows[0] = '{24'h006f0f, 1'b1, 3'h3, 1'b0, p_sh};
    rows[1] = '{24'h046f0f, 1'b0, 3'h0, 1'b0, p_vc};
    rows[2] = '{24'h066f0f, 1'b0, 3'h0, 1'b0, p_vc};
    rows[3] = '{24'h056f0f, 1'b1, 3'h7, 1'b0, p_sh};
    rows[4] = '{24'h446f0f, 1'b1, 3'h5, 1'b0, p_sh};
    rows[5] = '{24'h846f0f, 1'b0, 3'h0, 1'b0, p_vc};
    rows[6] = '{24'h000f0f, 1'b1, 3'h4, 1'b1, p_sh};
    rows[7] = '{24'h800f0f, 1'b0, 3'h0, 1'b1, p_lg};
    rows[8] = '{24'h050f0f, 1'b0, 3'h0, 1'b1, p_lg};
    rows[9] = '{24'hc0770f, 1'b0, 3'h0, 1'b0, p_vc};
    rows[10] = '{24'hc00e0f, 1'b0, 3'h0, 1'b0, p_vc};
    rows[11] = '{24'hc00d0f, 1'b0, 3'h0, 1'b0, p_vc};
    rows[12] = '{24'hc0710f, 1'b1, 3'h4, 1'b0, p_sh};
    rows[13] = '{24'hc0d50f, 1'b1, 3'h3, 1'b0, p_sh};
    rows[14] = '{24'h000090, 1'b0, 3'h0, 1'b0, p_vc};
    rows[15] = '{24'h400f0f, 1'b1, 3'h5, 1'b1, p_sh};
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    chk_idle();
    $display("test reset done");
    for (int i = 0; i < NROWS; i++)
    begin
      ln = {ilp_pkg::LINE_BYTES{8'h90}};
      ln[23:0] = rows[i].b;
      u_fill.put_line(i[IDX_W-1:0], ln);
    end
    for (int i = 0; i < NROWS; i++)
    begin
      lookup(i[IDX_W-1:0], 5'h00, rows[i].pred, rows[i].len, rows[i].pf, 1'b0, rows[i].path);
    end
    $display("test table done");
    ln = {ilp_pkg::LINE_BYTES{8'h90}};
    ln[47:0] = 48'hc06f0fc06f0f;
    u_fill.put_line(6'h14, ln);
    lookup(6'h14, 5'h00, 1'b1, 3'h3, 1'b0, 1'b1, p_sh);
    lookup(6'h14, 5'h03, 1'b1, 3'h3, 1'b0, 1'b0, p_sh);
    ln = {ilp_pkg::LINE_BYTES{8'h90}};
    ln[255:232] = 24'hc06f0f;
    u_fill.put_line(6'h15, ln);
    lookup(6'h15, 5'h1d, 1'b1, 3'h3, 1'b0, 1'b0, p_sh);
    ln = {ilp_pkg::LINE_BYTES{8'h90}};
    ln[255:240] = 16'h6f0f;
    u_fill.put_line(6'h16, ln);
    lookup(6'h16, 5'h1e, 1'b0, 3'h0, 1'b0, 1'b0, p_vc);
    $display("test pairing and line end done");
    @(posedge clock);
    rd_valid <= 1'b1;
    rd_line <= 6'h00;
    rd_offset <= 5'h00;
    @(posedge clock);
    rd_line <= 6'h01;
    @(posedge clock);
    rd_line <= 6'h06;
    #1;
    chk(res_valid === 1'b1 && res_pred === 1'b1 && res_len === 3'h3, "first piped answer");
    @(posedge clock);
    rd_valid <= 1'b0;
    #1;
    chk(res_valid === 1'b1 && res_pred === 1'b0 && res_path === p_vc, "second piped answer");
    @(posedge clock);
    #1;
    chk(res_valid === 1'b1 && res_pf === 1'b1 && res_len === 3'h4, "third piped answer");
    $display("test back to back done");
    // second reset in mid run
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    #1;
    chk_idle();
    @(posedge clock);
    sys_rst <= 1'b0;
    lookup(6'h03, 5'h00, 1'b1, 3'h7, 1'b0, 1'b0, p_sh);
    $display("test mid run reset done");
    final_report();
  end
endmodule
